// ### hw/dac_host_loader.sv
// host end: frames a 16 bit word and optionally pulses latch update
`timescale 1ns/10ps
`include "dac_load_cfg.svh"
module dac_host_loader #(
    parameter int WIDTH = `WORD_BITS
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 start,
    input  wire logic [WIDTH-1:0]     word,
    input  wire logic                 use_update,
    dac_link_if.host                  link,
    output logic                      busy_q,
    output logic                      done_q
);
    initial
    begin
        if (WIDTH != `WORD_BITS)
            $error("width must be 16");
    end

    localparam logic [3:0] HALF  = 4'(`SCLK_HALF_CYC);
    localparam logic [3:0] SETUP = 4'(`SETUP_CYC);

    dac_load_pkg::host_state_t st_q, st_d;
    logic [WIDTH-1:0] sh_q, sh_d;
    logic [4:0]       bits_q, bits_d;
    logic [3:0]       tm_q, tm_d;
    logic             upd_q, upd_d, cs_q, cs_d, sck_q, sck_d, din_q, din_d, lu_q, lu_d;
    logic             done_d;

    assign link.cs_n           = cs_q;
    assign link.sclk           = sck_q;
    assign link.din            = din_q;
    assign link.latch_update_n = lu_q;

    // sequencer: select low, 16 clocks msb first, select high, optional pulse
    always_comb
    begin
        st_d = st_q; sh_d = sh_q; bits_d = bits_q; tm_d = tm_q; upd_d = upd_q;
        cs_d = cs_q; sck_d = sck_q; din_d = din_q; lu_d = 1'b1; done_d = 1'b0;
        if (tm_q != 4'h0)
            tm_d = tm_q - 4'h1;
        unique case (st_q)
            dac_load_pkg::H_IDLE:
                if (start)
                begin
                    sh_d = word; upd_d = use_update; bits_d = '0;
                    cs_d = 1'b0;                         // [RQ1]
                    din_d = word[WIDTH-1];               // [RQ13]
                    tm_d = SETUP; st_d = dac_load_pkg::H_SETUP;
                end
            dac_load_pkg::H_SETUP:
                if (tm_q == 4'h0)
                    st_d = dac_load_pkg::H_HIGH;
            dac_load_pkg::H_HIGH:
                if (tm_q == 4'h0)
                begin
                    sck_d = 1'b1; tm_d = HALF;           // dac samples here
                    sh_d = {sh_q[WIDTH-2:0], 1'b0};
                    bits_d = bits_q + 5'h01;
                    st_d = dac_load_pkg::H_LOW;
                end
            dac_load_pkg::H_LOW:
                if (tm_q == 4'h0)
                begin
                    sck_d = 1'b0; tm_d = HALF; din_d = sh_q[WIDTH-1];
                    st_d = (bits_q == 5'(WIDTH)) ? dac_load_pkg::H_DONE
                                                 : dac_load_pkg::H_HIGH; // [RQ4]
                end
            dac_load_pkg::H_DONE:
                if (tm_q == 4'h0)
                begin
                    cs_d = 1'b1; tm_d = SETUP;
                    st_d = upd_q ? dac_load_pkg::H_PULSE : dac_load_pkg::H_IDLE;
                    done_d = !upd_q;
                end
            // hold update high for the setup time, then low for three cycles
            dac_load_pkg::H_PULSE:
            begin
                if (upd_q)
                begin
                    if (tm_q == 4'h0)
                    begin
                        lu_d = 1'b0;                     // [RQ7] low only after select high
                        tm_d = SETUP;
                        upd_d = 1'b0;
                    end
                end
                else if (tm_q == 4'h0)
                begin
                    done_d = 1'b1;
                    st_d = dac_load_pkg::H_IDLE;
                end
                else
                    lu_d = 1'b0;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= dac_load_pkg::H_IDLE; sh_q <= '0; bits_q <= '0; tm_q <= '0;
            upd_q <= 1'b0; cs_q <= 1'b1; sck_q <= 1'b0; din_q <= 1'b0; lu_q <= 1'b1;
            busy_q <= 1'b0; done_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d; sh_q <= sh_d; bits_q <= bits_d; tm_q <= tm_d;
            upd_q <= upd_d; cs_q <= cs_d; sck_q <= sck_d; din_q <= din_d; lu_q <= lu_d;
            busy_q <= (st_d != dac_load_pkg::H_IDLE);
            done_q <= done_d;
        end
    end
endmodule

// ### hw/dac_load_cfg.svh
// constants and behaviour summary of the serial dac word loader
// Behaviour
// RQ1: select falling edge opens each load
// RQ2: shift one bit per serial clock rise
// RQ3: after sixteen bits, latch on select rise
// RQ4: host holds select low all sixteen bits
// RQ5: host resends full word after disturbed load; host here never resends, word_error_q is not fed back
// RQ6: latch update low after select high loads
// RQ7: host holds latch update high while loading
// RQ8: reset clears latch, unipolar output zero
// RQ9: reset state gives bipolar minus reference
// RQ10: low twelve ladder, upper four decode segments
// RQ11: latch update falling edge loads latch
// RQ12: bipolar offset binary, 8000 is zero
// RQ13: words shifted most significant bit first
`ifndef DAC_LOAD_CFG_SVH
`define DAC_LOAD_CFG_SVH
`define WORD_BITS       16
`define LADDER_BITS     12
`define SEG_BITS        4
`define SEG_COUNT       15
`define LATCH_RESET     16'h0000
`define BIPOLAR_ZERO    16'h8000
`define CLK_PERIOD_NS   40
`define SCLK_HALF_NS    80
`define SCLK_HALF_CYC   ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS        50
`define SETUP_CYC       ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### hw/dac_load_pkg.sv
// types for the host end of the serial dac link
package dac_load_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_DONE, H_PULSE} host_state_t;
endpackage

// ### hw/dac_link_if.sv
// three wire plus latch update link between host and dac
`timescale 1ns/10ps
interface dac_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic latch_update_n;
    modport host (output cs_n, output sclk, output din, output latch_update_n);
    modport dac  (input cs_n, input sclk, input din, input latch_update_n);
endinterface

// ### hw/dac_word_loader.sv
// dac end: serial input register, dac latch and segment decode
`timescale 1ns/10ps
`include "dac_load_cfg.svh"
module dac_word_loader #(
    parameter int WIDTH = `WORD_BITS
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    dac_link_if.dac                      link,
    output logic [WIDTH-1:0]             latch_q,
    output logic [`LADDER_BITS-1:0]      ladder_q,
    output logic [`SEG_COUNT-1:0]        segments_q,
    output logic                         word_error_q
);
    initial
    begin
        if (WIDTH != `WORD_BITS)
            $error("width must be 16");
    end

    // thermometer decode of the upper bits onto matched segments
    function automatic logic [`SEG_COUNT-1:0] seg_decode(input logic [`SEG_BITS-1:0] v);
        logic [`SEG_COUNT-1:0] t;
        t = '0;
        for (int i = 0; i < `SEG_COUNT; i++)
            t[i] = (32'(v) > i);
        return t;
    endfunction

    logic [2:0] cs_s_q, cs_s_d, sck_s_q, sck_s_d, din_s_q, din_s_d, lu_s_q, lu_s_d;
    logic [WIDTH-1:0] shift_q, shift_d, latch_d;
    logic [4:0]       count_q, count_d;
    logic             active_q, active_d, err_d;
    logic             cs_fall, cs_rise, sck_rise, lu_fall;

    // two stage synchronisers plus one history stage for edges
    always_comb
    begin
        cs_s_d  = {cs_s_q[1:0], link.cs_n};
        sck_s_d = {sck_s_q[1:0], link.sclk};
        din_s_d = {din_s_q[1:0], link.din};
        lu_s_d  = {lu_s_q[1:0], link.latch_update_n};
    end

    assign cs_fall  = cs_s_q[2] & ~cs_s_q[1];
    assign cs_rise  = ~cs_s_q[2] & cs_s_q[1];
    assign sck_rise = ~sck_s_q[2] & sck_s_q[1];
    assign lu_fall  = lu_s_q[2] & ~lu_s_q[1];

    // frame tracking, shifting and latch transfer
    always_comb
    begin
        active_d = active_q;
        shift_d  = shift_q;
        count_d  = count_q;
        latch_d  = latch_q;
        err_d    = word_error_q;
        if (cs_fall)
        begin
            active_d = 1'b1;                             // [RQ1]
            count_d  = '0;
        end
        else if (active_q && !cs_s_q[1] && sck_rise)
        begin
            shift_d = {shift_q[WIDTH-2:0], din_s_q[1]};  // [RQ2] [RQ13]
            if (count_q != 5'(WIDTH))
                count_d = count_q + 5'h01;
        end
        if (cs_rise && active_q)
        begin
            active_d = 1'b0;
            if (count_q == 5'(WIDTH))
            begin
                latch_d = shift_q;                       // [RQ3]
                err_d   = 1'b0;
            end
            else
                err_d = 1'b1;                            // short frame leaves latch stale
        end
        if (lu_fall && cs_s_q[1] && !active_q)
            latch_d = shift_q;                           // [RQ6] [RQ11]
    end

    // registers; reset clears the latch to code zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cs_s_q       <= 3'h7;
            sck_s_q      <= 3'h0;
            din_s_q      <= 3'h0;
            lu_s_q       <= 3'h7;
            shift_q      <= '0;
            count_q      <= '0;
            active_q     <= 1'b0;
            latch_q      <= `LATCH_RESET;                // [RQ8] [RQ9]
            ladder_q     <= '0;
            segments_q   <= '0;
            word_error_q <= 1'b0;
        end
        else
        begin
            cs_s_q       <= cs_s_d;
            sck_s_q      <= sck_s_d;
            din_s_q      <= din_s_d;
            lu_s_q       <= lu_s_d;
            shift_q      <= shift_d;
            count_q      <= count_d;
            active_q     <= active_d;
            latch_q      <= latch_d;                     // [RQ12] offset binary as stored
            ladder_q     <= latch_d[`LADDER_BITS-1:0];   // [RQ10]
            segments_q   <= seg_decode(latch_d[WIDTH-1:`LADDER_BITS]); // [RQ10]
            word_error_q <= err_d;
        end
    end
endmodule

// ### verification/dac_link_asserts.sv
// assertions on the joined host to dac link
`timescale 1ns/10ps
module dac_link_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic latch_update_n
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // framing, serial clock shape and latch update pulse
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("sclk high outside frame");
    a_select_setup: assert property ($fell(cs_n) |-> !sclk [*2])
        else $error("sclk too soon after select");
    a_din_held_high: assert property (sclk && $past(sclk) |-> $stable(din))
        else $error("din moved while sclk high");
    a_sclk_high_span: assert property ($rose(sclk) |-> sclk [*2] ##[1:4] !sclk)
        else $error("sclk high phase wrong");
    a_frame_bounded: assert property ($fell(cs_n) |-> ##[60:160] $rose(cs_n))
        else $error("frame length wrong");
    a_update_idle_frame: assert property (!cs_n |-> latch_update_n)
        else $error("update low inside frame");
    a_update_width: assert property ($fell(latch_update_n) |->
        !latch_update_n [*3] ##1 latch_update_n) else $error("update pulse width");
    a_update_after_rise: assert property ($fell(latch_update_n) |-> cs_n && $past(cs_n, 2))
        else $error("update not after select rise");
endmodule

// ### verification/serial_dac_word_loader_tb.sv
// bench: host and dac joined, plus a bench-driven link to a second dac
`timescale 1ns/10ps
module serial_dac_word_loader_tb;
    logic        clk;
    logic        rst;
    logic        start;
    logic [15:0] word;
    logic        use_update;
    logic        done_q;
    logic [15:0] latch_q;
    logic [15:0] latch_b_q;
    logic [11:0] ladder_q;
    logic [14:0] segments_q;
    logic        error_q;
    logic        error_b_q;
    logic [15:0] wire_q;
    logic        sclk_q;
    int          err_total = 0;
    int          comparisons = 0;
    int          cycles = 0;
    dac_link_if  link_a ();
    dac_link_if  link_b ();
    dac_host_loader i_dac_host_loader (.clk(clk), .rst(rst), .start(start), .word(word),
        .use_update(use_update), .link(link_a), .busy_q(), .done_q(done_q));
    dac_word_loader i_dac_word_loader (.clk(clk), .rst(rst), .link(link_a), .latch_q(latch_q),
        .ladder_q(ladder_q), .segments_q(segments_q), .word_error_q(error_q));
    dac_word_loader i_dac_word_loader_b (.clk(clk), .rst(rst), .link(link_b),
        .latch_q(latch_b_q), .ladder_q(), .segments_q(), .word_error_q(error_b_q));
    dac_link_asserts i_dac_link_asserts (.clk(clk), .rst(rst), .cs_n(link_a.cs_n),
        .sclk(link_a.sclk), .din(link_a.din), .latch_update_n(link_a.latch_update_n));
    // 25 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // cycle ceiling and capture of bits seen on the joined wire
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        sclk_q <= link_a.sclk;
        if (link_a.sclk && !sclk_q)
            wire_q <= {wire_q[14:0], link_a.din};
        if (cycles == 20000)
        begin
            err_total++;
            conclude();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [15:0] seg_of(input logic [3:0] c);
        seg_of = 16'h0000;
        for (int i = 0; i < 15; i++)
            seg_of[i] = (c > i);
    endfunction
    task automatic conclude();
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one word through the host end, checked on wire and at the dac
    task automatic host_load(input logic [15:0] w, input logic upd);
        int n;
        start = 1'b1;
        word = w;
        use_update = upd;
        tick(1);
        start = 1'b0;
        for (n = 0; n < 400 && done_q !== 1'b1; n++)
            tick(1);
        chk("done", 16'h0001, {15'h0000, done_q});
        tick(8);
        chk("wire", w, wire_q);
        chk("latch", w, latch_q);
        chk("ladder", {4'h0, w[11:0]}, {4'h0, ladder_q});
        chk("segments", seg_of(w[15:12]), {1'b0, segments_q});
        chk("error", 16'h0000, {15'h0000, error_q});
    endtask
    // bench frame of nb bits, msb first, 320 ns serial clock
    task automatic frame_b(input logic [15:0] w, input int nb);
        link_b.cs_n = 1'b0;
        tick(4);
        for (int i = 15; i > 15 - nb; i--)
        begin
            link_b.din = w[i];
            tick(4);
            link_b.sclk = 1'b1;
            tick(4);
            link_b.sclk = 1'b0;
        end
        tick(4);
        link_b.cs_n = 1'b1;
        link_b.din = ~link_b.din;
        tick(10);
    endtask
    // reset, host corners and sweep, then short frame and latch update
    initial
    begin
        logic [15:0] w;
        logic [15:0] s;
        rst = 1'b1;
        start = 1'b0;
        word = 16'h0000;
        use_update = 1'b0;
        link_b.cs_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.din = 1'b0;
        link_b.latch_update_n = 1'b1;
        void'($urandom(54));
        tick(6);
        rst = 1'b0;
        tick(1);
        chk("latch", 16'h0000, latch_q);
        chk("segments", 16'h0000, {1'b0, segments_q});
        host_load(16'h8000, 1'b0);
        host_load(16'hffff, 1'b1);
        for (int c = 0; c < 16; c++)
            host_load({c[3:0], 12'($urandom)}, 1'($urandom));
        w = 16'($urandom);
        frame_b(w, 16);
        chk("latch_b", w, latch_b_q);
        s = 16'($urandom);
        frame_b(s, 9);
        chk("latch_b", w, latch_b_q);
        chk("error_b", 16'h0001, {15'h0000, error_b_q});
        s = {w[6:0], s[15:7]};
        link_b.latch_update_n = 1'b0;
        tick(4);
        link_b.latch_update_n = 1'b1;
        tick(8);
        chk("latch_b", s, latch_b_q);
        w = 16'($urandom);
        frame_b(w, 16);
        chk("latch_b", w, latch_b_q);
        chk("error_b", 16'h0000, {15'h0000, error_b_q});
        conclude();
    end
endmodule
